// file: rtl/fsl_map.svh
/*
  register offsets, reset values and pattern timing of the status led sequencer.
  assumes a 100 MHz system clock; included by the sequencer only.
*/
`ifndef FSL_MAP_SVH
`define FSL_MAP_SVH
`define FSL_ADR_CTRL 8'h00
`define FSL_ADR_PRESCALE 8'h04
`define FSL_ADR_STATUS 8'h08
`define FSL_CTRL_PERS_LSB 0
`define FSL_CTRL_PERS_RST 2'h0
`define FSL_ST_PAT_LSB 0
`define FSL_ST_RED_BIT 4
`define FSL_ST_GREEN_BIT 5
`define FSL_ST_STEP_LSB 6
`define FSL_ST_COL_BIT 9
`define FSL_CLK_PERIOD_NS 10
`define FSL_MS_NS 1000000
`define FSL_MS_CYCLES (`FSL_MS_NS / `FSL_CLK_PERIOD_NS)
`define FSL_FLICKER_MS 10'd50
`define FSL_BLINK_MS 10'd200
`define FSL_FLASH_MS 10'd200
`define FSL_GAP_MS 10'd200
`define FSL_LONG_OFF_MS 10'd1000
`define FSL_R13_ON_MS 10'd250
`define FSL_R13_OFF_MS 10'd750
`define FSL_ACYC_SHORT_MS 10'd100
`define FSL_ACYC_LONG_MS 10'd700
`endif

// file: rtl/fsl_pkg.sv
/*
  types of the status led sequencer: personalities, patterns, colours, phases.
  assumes nothing of its surroundings.
*/
package fsl_pkg;
  typedef enum logic [1:0] {PERS_PB_MASTER, PERS_PB_SLAVE, PERS_CAN_MASTER,
                            PERS_DN_MASTER} fsl_pers_e;
  typedef enum logic [3:0] {P_OFF, P_ON, P_FLICKER, P_BLINK, P_SFLASH, P_DFLASH,
                            P_TFLASH, P_R13, P_ACYC, P_ALT} fsl_pat_e;
  typedef enum logic {C_RED, C_GREEN} fsl_col_e;
  typedef struct packed {
    logic lit;
    logic [9:0] dur;
    logic last;
  } fsl_phase_s;
endpackage

// file: rtl/fsl_led_seq.sv
/*
  two-colour fieldbus communication status led sequencer with wishbone registers.
  assumes status inputs synchronous to CLK_SYS_IN and a classic wishbone master.
*/
// The implementer's own choices: the register offsets and the Wishbone register port.
// Operation
// - flicker: 50 ms lit, 50 ms dark, repeating.
// - blink: 200 ms lit, 200 ms dark, repeating.
// - single flash: 200 ms lit then 1000 ms dark.
// - double flash: two 200 ms pulses, 200 ms gap, then 1000 ms dark.
// - triple flash: three 200 ms pulses, 200 ms gaps, then 1000 ms dark.
// - steady on keeps colour lit; off keeps both colours dark.
// - can master: dark when no error and no node state.
// - can master: red single flash at error counter warning level.
// - can master: red double flash on guard or heartbeat event.
// - can master: steady red while bus off.
// - can master: green single flash while stopped.
// - can master: green blink while preoperational.
// - can master: steady green while operational.
// - fieldbus master: steady red when a slave is disconnected.
// - fieldbus master: irregular green flash on no configuration or stack error.
// - fieldbus master: regular green flash when configured, not released.
// - fieldbus master: steady green when all slaves communicate.
// - fieldbus slave: red 1:3 on stop, red 1:1 unconfigured, green run.
// - devicenet master: steady green online with an established connection.
// - devicenet: green flash no connection, red flash timeout, alternate on fault.
// - devicenet master: steady red on duplicate address or bus off.
// - devicenet master: dark after start and during duplicate address check.
`timescale 1ns/1ps
`include "fsl_map.svh"
module fsl_led_seq #(
  parameter int MS_CYCLES = `FSL_MS_CYCLES,
  parameter int PRE_W = 20
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic PBM_SLAVE_DISC_IN,
  input wire logic PBM_NO_CONFIG_IN,
  input wire logic PBM_STACK_ERR_IN,
  input wire logic PBM_CONFIGURED_IN,
  input wire logic PBM_RELEASED_IN,
  input wire logic PBM_ALL_OK_IN,
  input wire logic PBS_STOP_IN,
  input wire logic PBS_UNCONFIG_IN,
  input wire logic PBS_RUN_IN,
  input wire logic CAN_WARN_IN,
  input wire logic CAN_ERR_EVT_IN,
  input wire logic CAN_BUS_OFF_IN,
  input wire logic CAN_STOPPED_IN,
  input wire logic CAN_PREOP_IN,
  input wire logic CAN_OPER_IN,
  input wire logic DN_CRIT_FAIL_IN,
  input wire logic DN_COMM_FAULT_IN,
  input wire logic DN_CONN_TIMEOUT_IN,
  input wire logic DN_DUP_CHECK_IN,
  input wire logic DN_ONLINE_IN,
  input wire logic DN_CONN_EST_IN,
  output logic LED_RED_OUT,
  output logic LED_GREEN_OUT
);
  localparam logic [PRE_W-1:0] PRE_RST = PRE_W'(MS_CYCLES);

  fsl_pkg::fsl_pers_e pers;
  logic [PRE_W-1:0] prescale;
  logic [PRE_W-1:0] pre_cnt;
  logic [PRE_W-1:0] pre_max;
  logic tick;
  logic [9:0] ms_cnt;
  logic [2:0] step;
  fsl_pkg::fsl_pat_e cur_pat;
  fsl_pkg::fsl_pat_e sel_pat;
  fsl_pkg::fsl_col_e cur_col;
  fsl_pkg::fsl_col_e sel_col;
  fsl_pkg::fsl_phase_s ph;
  logic restart;
  logic wb_req;

  // n flashes of 200 ms with 200 ms gaps, closed by the long dark phase
  function automatic fsl_pkg::fsl_phase_s flash_phase(input logic [2:0] n,
                                                       input logic [2:0] s);
    fsl_pkg::fsl_phase_s p;
    p.lit = !s[0];
    p.last = (s == 3'((n << 1) - 3'h1));
    p.dur = p.lit ? `FSL_FLASH_MS : (p.last ? `FSL_LONG_OFF_MS : `FSL_GAP_MS);
    return p;
  endfunction

  function automatic fsl_pkg::fsl_phase_s two_phase(input logic [2:0] s,
                                                     input logic [9:0] on_ms,
                                                     input logic [9:0] off_ms);
    fsl_pkg::fsl_phase_s p;
    p.lit = (s == 3'h0);
    p.last = (s != 3'h0);
    p.dur = p.lit ? on_ms : off_ms;
    return p;
  endfunction

  function automatic fsl_pkg::fsl_phase_s pat_phase(input fsl_pkg::fsl_pat_e pat,
                                                     input logic [2:0] s);
    fsl_pkg::fsl_phase_s p;
    p = '{lit: 1'b0, dur: 10'h001, last: 1'b1};
    case (pat)
      fsl_pkg::P_ON: p = '{lit: 1'b1, dur: 10'h001, last: 1'b1};
      fsl_pkg::P_FLICKER: p = two_phase(s, `FSL_FLICKER_MS, `FSL_FLICKER_MS);
      fsl_pkg::P_BLINK: p = two_phase(s, `FSL_BLINK_MS, `FSL_BLINK_MS);
      fsl_pkg::P_ALT: p = two_phase(s, `FSL_BLINK_MS, `FSL_BLINK_MS);
      fsl_pkg::P_R13: p = two_phase(s, `FSL_R13_ON_MS, `FSL_R13_OFF_MS);
      fsl_pkg::P_SFLASH: p = flash_phase(3'h1, s);
      fsl_pkg::P_DFLASH: p = flash_phase(3'h2, s);
      fsl_pkg::P_TFLASH: p = flash_phase(3'h3, s);
      fsl_pkg::P_ACYC: begin
        // uneven gaps so it cannot be mistaken for the regular flash
        p.lit = !s[0];
        p.last = (s == 3'h3);
        p.dur = (s == 3'h3) ? `FSL_ACYC_LONG_MS : `FSL_ACYC_SHORT_MS;
      end
      default: p = '{lit: 1'b0, dur: 10'h001, last: 1'b1};
    endcase
    return p;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // severity order inside each personality, errors first
  always_comb begin
    sel_pat = fsl_pkg::P_OFF;
    sel_col = fsl_pkg::C_RED;
    case (pers)
      fsl_pkg::PERS_PB_MASTER: begin
        if (PBM_SLAVE_DISC_IN) begin
          sel_pat = fsl_pkg::P_ON;
        end else if (PBM_NO_CONFIG_IN || PBM_STACK_ERR_IN) begin
          sel_pat = fsl_pkg::P_ACYC;
          sel_col = fsl_pkg::C_GREEN;
        end else if (PBM_ALL_OK_IN) begin
          sel_pat = fsl_pkg::P_ON;
          sel_col = fsl_pkg::C_GREEN;
        end else if (PBM_CONFIGURED_IN && !PBM_RELEASED_IN) begin
          sel_pat = fsl_pkg::P_BLINK;
          sel_col = fsl_pkg::C_GREEN;
        end
      end
      fsl_pkg::PERS_PB_SLAVE: begin
        if (PBS_STOP_IN) begin
          sel_pat = fsl_pkg::P_R13;
        end else if (PBS_UNCONFIG_IN) begin
          sel_pat = fsl_pkg::P_BLINK;
        end else if (PBS_RUN_IN) begin
          sel_pat = fsl_pkg::P_ON;
          sel_col = fsl_pkg::C_GREEN;
        end
      end
      fsl_pkg::PERS_CAN_MASTER: begin
        if (CAN_BUS_OFF_IN) begin
          sel_pat = fsl_pkg::P_ON;
        end else if (CAN_ERR_EVT_IN) begin
          sel_pat = fsl_pkg::P_DFLASH;
        end else if (CAN_WARN_IN) begin
          sel_pat = fsl_pkg::P_SFLASH;
        end else if (CAN_OPER_IN) begin
          sel_pat = fsl_pkg::P_ON;
          sel_col = fsl_pkg::C_GREEN;
        end else if (CAN_PREOP_IN) begin
          sel_pat = fsl_pkg::P_BLINK;
          sel_col = fsl_pkg::C_GREEN;
        end else if (CAN_STOPPED_IN) begin
          sel_pat = fsl_pkg::P_SFLASH;
          sel_col = fsl_pkg::C_GREEN;
        end else begin
          sel_pat = fsl_pkg::P_OFF;
        end
      end
      fsl_pkg::PERS_DN_MASTER: begin
        if (DN_CRIT_FAIL_IN) begin
          sel_pat = fsl_pkg::P_ON;
        end else if (DN_COMM_FAULT_IN) begin
          sel_pat = fsl_pkg::P_ALT;
        end else if (DN_CONN_TIMEOUT_IN) begin
          sel_pat = fsl_pkg::P_BLINK;
        end else if (DN_DUP_CHECK_IN) begin
          sel_pat = fsl_pkg::P_OFF;
        end else if (DN_ONLINE_IN && DN_CONN_EST_IN) begin
          sel_pat = fsl_pkg::P_ON;
          sel_col = fsl_pkg::C_GREEN;
        end else if (DN_ONLINE_IN) begin
          sel_pat = fsl_pkg::P_BLINK;
          sel_col = fsl_pkg::C_GREEN;
        end
      end
      default: sel_pat = fsl_pkg::P_OFF;
    endcase
  end

  assign restart = (sel_pat != cur_pat) || (sel_col != cur_col);
  assign ph = pat_phase(cur_pat, step);
  // zero prescale behaves as one cycle per tick rather than stalling
  assign pre_max = (prescale == '0) ? '0 : prescale - PRE_W'(1);
  assign tick = (pre_cnt >= pre_max);
  assign wb_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN || restart) begin
      pre_cnt <= '0;
    end else if (tick) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + PRE_W'(1);
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      cur_pat <= fsl_pkg::P_OFF;
      cur_col <= fsl_pkg::C_RED;
      step <= 3'h0;
      ms_cnt <= 10'h000;
    end else if (restart) begin
      cur_pat <= sel_pat;
      cur_col <= sel_col;
      step <= 3'h0;
      ms_cnt <= 10'h000;
    end else if (tick) begin
      if (ms_cnt >= ph.dur - 10'h001) begin
        ms_cnt <= 10'h000;
        step <= ph.last ? 3'h0 : step + 3'h1;
      end else begin
        ms_cnt <= ms_cnt + 10'h001;
      end
    end
  end

  // one cycle of lag from the phase state keeps both outputs on flops
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      LED_RED_OUT <= 1'b0;
      LED_GREEN_OUT <= 1'b0;
    end else if (cur_pat == fsl_pkg::P_ALT) begin
      LED_RED_OUT <= ph.lit;
      LED_GREEN_OUT <= !ph.lit;
    end else begin
      LED_RED_OUT <= ph.lit && (cur_col == fsl_pkg::C_RED);
      LED_GREEN_OUT <= ph.lit && (cur_col == fsl_pkg::C_GREEN);
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      WB_ACK_OUT <= wb_req;
      WB_DAT_OUT <= 32'h0000_0000;
      if (wb_req && !WB_WE_IN) begin
        case (WB_ADR_IN)
          `FSL_ADR_CTRL: WB_DAT_OUT[`FSL_CTRL_PERS_LSB +: 2] <= pers;
          `FSL_ADR_PRESCALE: WB_DAT_OUT[PRE_W-1:0] <= prescale;
          `FSL_ADR_STATUS: begin
            WB_DAT_OUT[`FSL_ST_PAT_LSB +: 4] <= cur_pat;
            WB_DAT_OUT[`FSL_ST_RED_BIT] <= LED_RED_OUT;
            WB_DAT_OUT[`FSL_ST_GREEN_BIT] <= LED_GREEN_OUT;
            WB_DAT_OUT[`FSL_ST_STEP_LSB +: 3] <= step;
            WB_DAT_OUT[`FSL_ST_COL_BIT] <= cur_col;
          end
          default: WB_DAT_OUT <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      pers <= fsl_pkg::fsl_pers_e'(`FSL_CTRL_PERS_RST);
      prescale <= PRE_RST;
    end else if (wb_req && WB_WE_IN) begin
      if (WB_ADR_IN == `FSL_ADR_CTRL) begin
        pers <= fsl_pkg::fsl_pers_e'(merge(32'(pers), WB_DAT_IN, WB_SEL_IN));
      end
      if (WB_ADR_IN == `FSL_ADR_PRESCALE) begin
        prescale <= PRE_W'(merge(32'(prescale), WB_DAT_IN, WB_SEL_IN));
      end
    end
  end

  sequence s_phase_end;
    tick && !restart && (ms_cnt >= ph.dur - 10'h001);
  endsequence

  a_ack_single: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    wb_req |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
    else $error("ack not a single cycle after request");
  a_off_dark_both: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (cur_pat == fsl_pkg::P_OFF) |=> !LED_RED_OUT && !LED_GREEN_OUT)
    else $error("led lit in off pattern");
  a_flicker_half: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (cur_pat == fsl_pkg::P_FLICKER && tick && !restart && ms_cnt == 10'd49)
    |=> step != $past(step))
    else $error("flicker phase not 50 ms");
  a_phase_hold: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (tick && !restart && ms_cnt < ph.dur - 10'h001) |=> $stable(step))
    else $error("phase ended early");
  a_long_dark: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (cur_pat == fsl_pkg::P_DFLASH && step == 3'h3 && !restart) |-> ph.dur == 10'd1000)
    else $error("double flash lacks long dark phase");
  a_seq_wrap: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (cur_pat == fsl_pkg::P_TFLASH && step == 3'h5 && s_phase_end) |=> step == 3'h0)
    else $error("triple flash did not wrap after sixth phase");
  a_restart_lit: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    restart |=> step == 3'h0 && ms_cnt == 10'h000 && pre_cnt == '0)
    else $error("pattern change did not restart");
  a_can_busoff_red: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (pers == fsl_pkg::PERS_CAN_MASTER && CAN_BUS_OFF_IN)[*3] |-> LED_RED_OUT && !LED_GREEN_OUT)
    else $error("bus off not steady red");
  a_dn_crit_wins: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (pers == fsl_pkg::PERS_DN_MASTER && DN_CRIT_FAIL_IN)
    |-> sel_pat == fsl_pkg::P_ON && sel_col == fsl_pkg::C_RED)
    else $error("critical link failure not steady red");
  a_pbm_disc_red: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (pers == fsl_pkg::PERS_PB_MASTER && PBM_SLAVE_DISC_IN)
    |-> sel_pat == fsl_pkg::P_ON && sel_col == fsl_pkg::C_RED)
    else $error("slave disconnect not steady red");
  a_alt_colour: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (cur_pat == fsl_pkg::P_ALT && !restart) |=> LED_RED_OUT != LED_GREEN_OUT)
    else $error("alternating pattern shows both or neither colour");
  a_tick_count: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (!tick && !restart) |=> pre_cnt == $past(pre_cnt) + PRE_W'(1))
    else $error("prescaler skipped a count");
endmodule

// file: tb/fsl_led_panel.sv
/*
  model of the two-colour front panel indicator: measures lit runs of each colour.
  assumes registered led drives, high = lit, sampled on the system clock.
*/
`timescale 1ns/1ps
module fsl_led_panel (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic red_in,
  input wire logic green_in,
  output logic [15:0] red_run_out,
  output logic [15:0] green_run_out,
  output logic [15:0] both_lit_out
);
  logic [15:0] red_cnt;
  logic [15:0] green_cnt;

  // a run is reported only once it has ended, so partial runs never show
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      red_cnt <= 16'h0;
      green_cnt <= 16'h0;
      red_run_out <= 16'h0;
      green_run_out <= 16'h0;
      both_lit_out <= 16'h0;
    end else begin
      red_cnt <= red_in ? red_cnt + 16'h1 : 16'h0;
      green_cnt <= green_in ? green_cnt + 16'h1 : 16'h0;
      if (!red_in && red_cnt != 16'h0) begin
        red_run_out <= red_cnt;
      end
      if (!green_in && green_cnt != 16'h0) begin
        green_run_out <= green_cnt;
      end
      // one bicolour die cannot show both colours at once
      if (red_in && green_in) begin
        both_lit_out <= both_lit_out + 16'h1;
      end
    end
  end
endmodule

// file: tb/fsl_led_seq_tb.sv
/*
  self-checking bench of the status led sequencer: all personalities, and all patterns except flicker and triple flash.
  assumes the panel model beside it and a 4-cycle reset millisecond, set to 3 to 5 cycles for each case in simulation.
*/
`timescale 1ns/1ps
module fsl_led_seq_tb;
  logic clk, rst, cyc, stb, we, ack, red, green;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, dat_out;
  logic [20:0] st;
  logic [15:0] red_run, green_run, both_lit, lfsr;
  int err_total, total_checks, pre;

  fsl_led_seq #(.MS_CYCLES(4)) uut (.CLK_SYS_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(dat_out), .WB_ACK_OUT(ack), .PBM_SLAVE_DISC_IN(st[0]),
    .PBM_NO_CONFIG_IN(st[1]), .PBM_STACK_ERR_IN(st[2]), .PBM_CONFIGURED_IN(st[3]),
    .PBM_RELEASED_IN(st[4]), .PBM_ALL_OK_IN(st[5]), .PBS_STOP_IN(st[6]),
    .PBS_UNCONFIG_IN(st[7]), .PBS_RUN_IN(st[8]), .CAN_WARN_IN(st[9]),
    .CAN_ERR_EVT_IN(st[10]), .CAN_BUS_OFF_IN(st[11]), .CAN_STOPPED_IN(st[12]),
    .CAN_PREOP_IN(st[13]), .CAN_OPER_IN(st[14]), .DN_CRIT_FAIL_IN(st[15]),
    .DN_COMM_FAULT_IN(st[16]), .DN_CONN_TIMEOUT_IN(st[17]), .DN_DUP_CHECK_IN(st[18]),
    .DN_ONLINE_IN(st[19]), .DN_CONN_EST_IN(st[20]), .LED_RED_OUT(red),
    .LED_GREEN_OUT(green));

  fsl_led_panel panel (.clk_in(clk), .rst_in(rst), .red_in(red), .green_in(green),
    .red_run_out(red_run), .green_run_out(green_run), .both_lit_out(both_lit));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // the leading edge waited for gives the idle cycle between two requests
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) check(32'h0, 32'h1, "bus answer missing");
  endtask

  function automatic int period_ms(input fsl_pkg::fsl_pat_e p);
    case (p)
      fsl_pkg::P_BLINK, fsl_pkg::P_ALT: return 400;
      fsl_pkg::P_SFLASH: return 1200;
      fsl_pkg::P_DFLASH: return 1600;
      fsl_pkg::P_TFLASH: return 2000;
      fsl_pkg::P_R13, fsl_pkg::P_ACYC: return 1000;
      default: return 100;
    endcase
  endfunction

  // expected {red, green} at a given millisecond after the restart
  function automatic logic [1:0] exp_leds(input fsl_pkg::fsl_pat_e p,
                                          input fsl_pkg::fsl_col_e c, input int ms);
    int t;
    logic lit;
    t = ms % period_ms(p);
    case (p)
      fsl_pkg::P_ON: lit = 1'b1;
      fsl_pkg::P_FLICKER: lit = t < 50;
      fsl_pkg::P_BLINK, fsl_pkg::P_ALT: lit = t < 200;
      fsl_pkg::P_SFLASH, fsl_pkg::P_DFLASH, fsl_pkg::P_TFLASH: lit = t < 200 ||
        (t >= 400 && t < 600 && p != fsl_pkg::P_SFLASH) ||
        (t >= 800 && t < 1000 && p == fsl_pkg::P_TFLASH);
      fsl_pkg::P_R13: lit = t < 250;
      fsl_pkg::P_ACYC: lit = t < 100 || (t >= 200 && t < 300);
      default: lit = 1'b0;
    endcase
    if (p == fsl_pkg::P_ALT) return lit ? 2'b10 : 2'b01;
    return (c == fsl_pkg::C_RED) ? {lit, 1'b0} : {1'b0, lit};
  endfunction

  task automatic run_case(input fsl_pkg::fsl_pers_e pe, input logic [20:0] m,
                          input fsl_pkg::fsl_pat_e p, input fsl_pkg::fsl_col_e c);
    int on;
    on = (p == fsl_pkg::P_FLICKER) ? 50 : (p == fsl_pkg::P_R13) ? 250 :
         (p == fsl_pkg::P_ACYC) ? 100 : (p == fsl_pkg::P_ON || p == fsl_pkg::P_OFF) ? 0 : 200;
    @(posedge clk);
    st <= 21'h0;
    lfsr = lfsr_next(lfsr);
    pre = 3 + int'(lfsr % 16'h3);
    wb_cycle(1'b1, 8'h04, 32'(pre));
    wb_cycle(1'b1, 8'h00, {30'h0, pe});
    repeat (4) @(posedge clk);
    st <= m;
    repeat (2) @(posedge clk);
    // sampled mid-millisecond so a one-cycle skew cannot decide the outcome
    for (int j = 0; j < period_ms(p) * pre; j++) begin
      @(negedge clk);
      if (j % pre == pre / 2) check({30'h0, red, green}, {30'h0, exp_leds(p, c, j / pre)},
                                    "led pattern");
    end
    wb_cycle(1'b0, 8'h08, 32'h0);
    check({28'h0, rdat[3:0]}, {28'h0, p}, "status pattern");
    if (p == fsl_pkg::P_ON) check({31'h0, rdat[9]}, {31'h0, c}, "status colour");
    if (on > 0) check({16'h0, (c == fsl_pkg::C_RED) ? red_run : green_run}, 32'(on * pre),
                      "lit run length");
    $display("case personality %0d pattern %0d done", pe, p);
  endtask

  initial begin
    repeat (120000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h0;
    sel = 4'h0;
    wdat = 32'h0;
    st = 21'h0;
    lfsr = 16'h26b3; // seed 9907
    repeat (8) @(posedge clk);
    check({30'h0, red, green}, 32'h0, "leds dark in reset");
    rst <= 1'b0;
    wb_cycle(1'b0, 8'h00, 32'h0);
    check(rdat, 32'h0, "personality reset");
    wb_cycle(1'b0, 8'h04, 32'h0);
    check(rdat, 32'h4, "prescale reset");
    wb_cycle(1'b1, 8'h10, 32'hffff_ffff);
    wb_cycle(1'b0, 8'h10, 32'h0);
    check(rdat, 32'h0, "unmapped read");
    run_case(fsl_pkg::PERS_PB_MASTER, 21'h1, fsl_pkg::P_ON, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_PB_MASTER, 21'h2, fsl_pkg::P_ACYC, fsl_pkg::C_GREEN);
    run_case(fsl_pkg::PERS_PB_MASTER, 21'h4, fsl_pkg::P_ACYC, fsl_pkg::C_GREEN);
    run_case(fsl_pkg::PERS_PB_MASTER, 21'h8, fsl_pkg::P_BLINK, fsl_pkg::C_GREEN);
    run_case(fsl_pkg::PERS_PB_MASTER, 21'h20, fsl_pkg::P_ON, fsl_pkg::C_GREEN);
    run_case(fsl_pkg::PERS_PB_MASTER, 21'h21, fsl_pkg::P_ON, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_PB_SLAVE, 21'h40, fsl_pkg::P_R13, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_PB_SLAVE, 21'h80, fsl_pkg::P_BLINK, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_PB_SLAVE, 21'h100, fsl_pkg::P_ON, fsl_pkg::C_GREEN);
    run_case(fsl_pkg::PERS_PB_SLAVE, 21'h140, fsl_pkg::P_R13, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_CAN_MASTER, 21'h0, fsl_pkg::P_OFF, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_CAN_MASTER, 21'h200, fsl_pkg::P_SFLASH, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_CAN_MASTER, 21'h400, fsl_pkg::P_DFLASH, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_CAN_MASTER, 21'h800, fsl_pkg::P_ON, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_CAN_MASTER, 21'hc00, fsl_pkg::P_ON, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_CAN_MASTER, 21'h1000, fsl_pkg::P_SFLASH, fsl_pkg::C_GREEN);
    run_case(fsl_pkg::PERS_CAN_MASTER, 21'h2000, fsl_pkg::P_BLINK, fsl_pkg::C_GREEN);
    run_case(fsl_pkg::PERS_CAN_MASTER, 21'h4000, fsl_pkg::P_ON, fsl_pkg::C_GREEN);
    run_case(fsl_pkg::PERS_CAN_MASTER, 21'h4200, fsl_pkg::P_SFLASH, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_DN_MASTER, 21'h8000, fsl_pkg::P_ON, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_DN_MASTER, 21'h10000, fsl_pkg::P_ALT, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_DN_MASTER, 21'h20000, fsl_pkg::P_BLINK, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_DN_MASTER, 21'h1c0000, fsl_pkg::P_OFF, fsl_pkg::C_RED);
    run_case(fsl_pkg::PERS_DN_MASTER, 21'h180000, fsl_pkg::P_ON, fsl_pkg::C_GREEN);
    run_case(fsl_pkg::PERS_DN_MASTER, 21'h80000, fsl_pkg::P_BLINK, fsl_pkg::C_GREEN);
    check({16'h0, both_lit}, 32'h0, "both colours lit");
    end_of_test();
  end
endmodule
